// ### rtl/brk_cond_if.sv
/*
  Carrier for one channel's programmed match condition between the top
  module and the channel matcher.
  Assumes the package brk_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
interface brk_cond_if;
  logic [15:0] addr;
  logic [15:0] data;
  logic [1:0]  size;
  logic        dir;
  logic        addr_en;
  logic        data_en;
  logic        dir_en;
  logic        hit;
  modport src (output addr, data, size, dir, addr_en, data_en, dir_en,
               input hit);
  modport cmp (input addr, data, size, dir, addr_en, data_en, dir_en,
               output hit);
endinterface : brk_cond_if
`default_nettype wire

// ### rtl/brk_match.sv
/*
  One break channel matcher: combinational compare of the bus access
  against the programmed condition.
  Assumes bus signals already in the processor clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module brk_match #(
  parameter bit HAS_DATA = 1'b1  // Data and direction qualifiers present
) (
  brk_cond_if.cmp          cond,     // Programmed condition
  input  wire logic [15:0] i_addr,   // Core address
  input  wire logic [15:0] i_data,   // Core data
  input  wire logic        i_write   // High for write cycle
);
  wire logic       addr_ok;
  wire logic       hi_ok;
  wire logic       lo_ok;
  wire logic       data_ok;
  wire logic       dir_ok;
  wire logic       any_en;

  assign addr_ok = !cond.addr_en || (i_addr == cond.addr);
  assign hi_ok   = i_data[15:8] == cond.data[15:8];
  assign lo_ok   = i_data[7:0] == cond.data[7:0];
  // Size picks which lanes take part
  assign data_ok = !HAS_DATA || !cond.data_en ||
                   (cond.size == brk_pkg::SIZE_HIGH ? hi_ok :
                    cond.size == brk_pkg::SIZE_LOW  ? lo_ok :
                    (hi_ok && lo_ok));
  assign dir_ok  = !HAS_DATA || !cond.dir_en ||
                   (i_write == (cond.dir == brk_pkg::DIR_WRITE));
  // Channel two ignores data and direction enables
  assign any_en  = cond.addr_en ||
                   (HAS_DATA && (cond.data_en || cond.dir_en));
  assign cond.hit = any_en && addr_ok && data_ok && dir_ok;
endmodule : brk_match
`default_nettype wire

// ### rtl/brk_pkg.sv
/*
  Constants for the hardware break comparator: bus widths, size codes,
  direction codes and reset values.
  Assumes a 16-bit address bus and a 16-bit data bus on the core side.
*/
package brk_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 2;
  // Access size qualifier codes
  localparam logic [1:0] SIZE_WORD = 2'h0;
  localparam logic [1:0] SIZE_HIGH = 2'h1;
  localparam logic [1:0] SIZE_LOW  = 2'h2;
  // Direction qualifier codes
  localparam logic DIR_READ  = 1'h0;
  localparam logic DIR_WRITE = 1'h1;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [15:0] RST_DATA = 16'h0000;
endpackage : brk_pkg

// ### rtl/hardware_break_comparator.sv
/*
  Hardware break comparator: two break channels watching the core bus,
  issuing a one-cycle halt request in the cycle after a matching access ends.
  Assumes the core presents address, data and direction with a one-cycle
  end-of-access strobe, all on i_clk; conditions are static while armed.
*/
`timescale 1ns/1ps
`default_nettype none
module hardware_break_comparator (
  input  wire logic        i_clk,          // 100 MHz system clock
  input  wire logic        i_rst,          // Async reset, active high
  input  wire logic        i_emu_activate, // Emulator activation pulse
  input  wire logic [15:0] i_bus_addr,     // Core address bus
  input  wire logic [15:0] i_bus_data,     // Core data bus
  input  wire logic        i_bus_write,    // High on write cycle
  input  wire logic        i_bus_end,      // Last cycle of an access
  input  wire logic        i_stepping,     // Core single-stepping
  input  wire logic        i_trap_exec,    // Software trap instruction
  input  wire logic        i_load,         // Load conditions strobe
  input  wire logic [15:0] i_c1_addr,      // Channel one address
  input  wire logic [15:0] i_c1_data,      // Channel one data
  input  wire logic [1:0]  i_c1_size,      // Channel one size code
  input  wire logic        i_c1_dir,       // Channel one direction
  input  wire logic        i_c1_addr_en,   // Channel one address enable
  input  wire logic        i_c1_data_en,   // Channel one data enable
  input  wire logic        i_c1_dir_en,    // Channel one direction enable
  input  wire logic [15:0] i_c2_addr,      // Channel two address
  input  wire logic        i_c2_addr_en,   // Channel two address enable
  output logic             o_halt_req,     // One-cycle halt request
  output logic [1:0]       o_hit_ch,       // Channels that matched
  output logic             o_wdt_enable    // Watchdog allowed to run
);
  // Debug session state; leaves normal run only on activation
  typedef enum logic {
    ST_NORMAL = 1'b0,
    ST_DEBUG  = 1'b1
  } mode_e;

  brk_cond_if c1 ();
  brk_cond_if c2 ();

  mode_e              mode;
  mode_e              next_mode;
  wire  logic         armed;

  wire  logic         take_cond;
  wire  logic         blocked;
  wire  logic         qualify;
  wire  logic         fire_c1;
  wire  logic         fire_c2;
  wire  logic         fire;
  wire  logic [1:0]   next_hit_ch;

  // Next values of the programmed conditions
  wire  logic [15:0]  next_c1_addr;
  wire  logic [15:0]  next_c1_data;
  wire  logic [1:0]   next_c1_size;
  wire  logic         next_c1_dir;
  wire  logic         next_c1_addr_en;
  wire  logic         next_c1_data_en;
  wire  logic         next_c1_dir_en;
  wire  logic [15:0]  next_c2_addr;
  wire  logic         next_c2_addr_en;

  // Condition word after this edge: a load replaces it
  function automatic logic [15:0] next_word(input logic        load,
                                            input logic [15:0] value,
                                            input logic [15:0] current);
    next_word = load ? value : current;
  endfunction : next_word

  // Enable after this edge: activation clears it, a load replaces it
  function automatic logic next_enable(input logic clear,
                                       input logic load,
                                       input logic value,
                                       input logic current);
    next_enable = clear ? 1'b0 : (load ? value : current);
  endfunction : next_enable

  // Activation wins over a load in the same cycle
  assign take_cond = i_load && !i_emu_activate;

  assign next_c1_addr    = next_word(take_cond, i_c1_addr, c1.addr);
  assign next_c1_data    = next_word(take_cond, i_c1_data, c1.data);
  assign next_c1_size    = take_cond ? i_c1_size : c1.size;
  assign next_c1_dir     = take_cond ? i_c1_dir : c1.dir;
  assign next_c2_addr    = next_word(take_cond, i_c2_addr, c2.addr);
  assign next_c1_addr_en = next_enable(i_emu_activate, i_load,
                                       i_c1_addr_en, c1.addr_en);
  assign next_c1_data_en = next_enable(i_emu_activate, i_load,
                                       i_c1_data_en, c1.data_en);
  assign next_c1_dir_en  = next_enable(i_emu_activate, i_load,
                                       i_c1_dir_en, c1.dir_en);
  assign next_c2_addr_en = next_enable(i_emu_activate, i_load,
                                       i_c2_addr_en, c2.addr_en);

  // Channel one match values; activation keeps them
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      c1.addr <= brk_pkg::RST_ADDR;
      c1.data <= brk_pkg::RST_DATA;
      c1.size <= brk_pkg::SIZE_WORD;
      c1.dir  <= brk_pkg::DIR_READ;
    end else begin
      c1.addr <= next_c1_addr;
      c1.data <= next_c1_data;
      c1.size <= next_c1_size;
      c1.dir  <= next_c1_dir;
    end
  end

  // Channel one qualifier enables, cleared on activation
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      c1.addr_en <= 1'b0;
      c1.data_en <= 1'b0;
      c1.dir_en  <= 1'b0;
    end else begin
      c1.addr_en <= next_c1_addr_en;
      c1.data_en <= next_c1_data_en;
      c1.dir_en  <= next_c1_dir_en;
    end
  end

  // Channel two address condition
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      c2.addr    <= brk_pkg::RST_ADDR;
      c2.addr_en <= 1'b0;
    end else begin
      c2.addr    <= next_c2_addr;
      c2.addr_en <= next_c2_addr_en;
    end
  end

  // Channel two has no data or direction path
  assign c2.data = brk_pkg::RST_DATA;
  assign c2.size = brk_pkg::SIZE_WORD;
  assign c2.dir = brk_pkg::DIR_READ;
  assign c2.data_en = 1'b0;
  assign c2.dir_en = 1'b0;

  brk_match #(.HAS_DATA(1'b1)) u_ch1 (
    .cond    (c1),
    .i_addr  (i_bus_addr),
    .i_data  (i_bus_data),
    .i_write (i_bus_write)
  );
  brk_match #(.HAS_DATA(1'b0)) u_ch2 (
    .cond    (c2),
    .i_addr  (i_bus_addr),
    .i_data  (i_bus_data),
    .i_write (i_bus_write)
  );

  // Session stays in debug until reset; breaks armed only there
  always_comb begin
    next_mode = mode;
    case (mode)
      ST_NORMAL: begin
        if (i_emu_activate) begin
          next_mode = ST_DEBUG;
        end
      end
      ST_DEBUG: begin
        next_mode = ST_DEBUG;
      end
      default: begin
        next_mode = ST_NORMAL;
      end
    endcase
  end

  assign armed = (mode == ST_DEBUG);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode <= ST_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  // Watchdog kept off once the emulator takes over
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wdt_enable <= 1'b1;
    end else begin
      o_wdt_enable <= (next_mode == ST_NORMAL);
    end
  end

  // Stepping or a software trap masks every channel
  assign blocked     = i_stepping || i_trap_exec;
  assign qualify     = armed && i_bus_end && !blocked;
  assign fire_c1     = qualify && c1.hit;
  assign fire_c2     = qualify && c2.hit;
  assign fire        = fire_c1 || fire_c2;
  assign next_hit_ch = {fire_c2, fire_c1};

  // Halt request for one cycle after the matching access
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_halt_req <= 1'b0;
      o_hit_ch   <= 2'h0;
    end else begin
      o_halt_req <= fire;
      o_hit_ch   <= next_hit_ch;
    end
  end
endmodule : hardware_break_comparator
`default_nettype wire

// ### sim/brk_props.sv
/* Port checker for the break comparator.
   Assumes binding to hardware_break_comparator, one clock. */
`timescale 1ns/1ps
`default_nettype none
module brk_props (
  input wire logic        i_clk, i_rst, i_emu_activate, i_bus_end, i_load,
  input wire logic        i_stepping, i_trap_exec, o_halt_req, o_wdt_enable,
  input wire logic [15:0] i_bus_addr, i_c2_addr,
  input wire logic [1:0]  o_hit_ch
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [15:0] c2_loaded;
  // Channel two address as the design latched it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) c2_loaded <= brk_pkg::RST_ADDR;
    else if (i_load && !i_emu_activate) c2_loaded <= i_c2_addr;
  end
  chk_halt_single: assert property (o_halt_req && !i_bus_end |=> !o_halt_req)
    else $error("halt longer than one cycle");
  chk_hit_pair: assert property (o_halt_req == (o_hit_ch != 2'h0))
    else $error("hit flags without halt");
  chk_halt_cause: assert property (o_halt_req |-> $past(i_bus_end))
    else $error("halt without access end");
  chk_step_block: assert property (i_stepping |=> !o_halt_req)
    else $error("halt while stepping");
  chk_trap_block: assert property (i_trap_exec |=> !o_halt_req)
    else $error("halt on trap");
  chk_wdt_off: assert property (i_emu_activate |=> !o_wdt_enable)
    else $error("watchdog on after activation");
  chk_wdt_hold: assert property (!o_wdt_enable |=> !o_wdt_enable)
    else $error("watchdog came back");
  chk_ch2_addr: assert property (o_hit_ch[1] |->
    $past(i_bus_addr) == $past(c2_loaded)) else $error("ch2 bad address");
  cov_ch1: cover property (o_hit_ch == 2'h1);
  cov_ch2: cover property (o_hit_ch == 2'h2);
  cov_act: cover property (i_emu_activate ##1 !o_wdt_enable);
  cov_b2b: cover property (o_halt_req ##1 o_halt_req);
endmodule : brk_props
bind hardware_break_comparator brk_props brk_props_i (.*);
`default_nettype wire

// ### sim/core_bus_model.sv
/* Core bus model: one-cycle access with end strobe.
   Assumes the bench holds i_go high one cycle per access. */
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
  input wire logic        i_go, i_w,
  input wire logic [15:0] i_a, i_d,
  output logic [15:0]     o_addr, o_data,
  output logic            o_write, o_end
);
  // Plain accesses only, never sleep steps or flash enable
  assign o_end = i_go;
  // Idle bus shows inverted values, not stale ones
  assign o_addr = i_go ? i_a : ~i_a;
  assign o_data = i_go ? i_d : ~i_d;
  assign o_write = i_go ? i_w : ~i_w;
endmodule : core_bus_model
`default_nettype wire

// ### sim/tb.sv
/* Table-driven bench for the break comparator.
   Assumes brk_pkg, the design and core_bus_model are compiled. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [6:0] f; logic [15:0] a, d;
    logic w; logic [1:0] ex;} row_s;
  logic clk = 0, rst = 1, act = 0, stp = 0, trp = 0, ld = 0, go = 0, w = 0;
  logic ae = 0, de = 0, re = 0, dr = 0, c2 = 0, bw, be, halt, wdt;
  logic [15:0] a = 16'h0, d = 16'h0, ba, bd;
  logic [1:0]  sz = 2'h0, hit;
  int mismatches = 0, check_count = 0;
  row_s blk;
  // Flags: addr_en, data_en, dir_en, size, dir, ch2 addr_en
  row_s rows[15] = '{'{7'h40,16'h1234,16'h0,1'h0,2'h1},
    '{7'h40,16'h1235,16'h0,1'h0,2'h0}, '{7'h20,16'h0,16'habcd,1'h0,2'h1},
    '{7'h20,16'h0,16'habce,1'h0,2'h0}, '{7'h24,16'h0,16'hab00,1'h0,2'h1},
    '{7'h24,16'h0,16'h00cd,1'h0,2'h0}, '{7'h28,16'h0,16'h00cd,1'h0,2'h1},
    '{7'h28,16'h0,16'hab00,1'h0,2'h0}, '{7'h50,16'h1234,16'h0,1'h0,2'h1},
    '{7'h50,16'h1234,16'h0,1'h1,2'h0}, '{7'h52,16'h1234,16'h0,1'h1,2'h1},
    '{7'h01,16'h4000,16'h0,1'h1,2'h2}, '{7'h60,16'h1234,16'habce,1'h0,2'h0},
    '{7'h21,16'h4000,16'h1111,1'h0,2'h2}, '{7'h2c,16'h0,16'habcd,1'h0,2'h1}};
  always #5 clk = ~clk;
  core_bus_model core_bus_model_i (.i_go(go), .i_w(w), .i_a(a), .i_d(d),
    .o_addr(ba), .o_data(bd), .o_write(bw), .o_end(be));
  hardware_break_comparator hardware_break_comparator_i (.i_clk(clk),
    .i_rst(rst), .i_emu_activate(act), .i_bus_addr(ba), .i_bus_data(bd),
    .i_bus_write(bw), .i_bus_end(be), .i_stepping(stp), .i_trap_exec(trp),
    .i_load(ld), .i_c1_addr(16'h1234), .i_c1_data(16'habcd), .i_c1_size(sz),
    .i_c1_dir(dr), .i_c1_addr_en(ae), .i_c1_data_en(de), .i_c1_dir_en(re),
    .i_c2_addr(16'h4000), .i_c2_addr_en(c2), .o_halt_req(halt),
    .o_hit_ch(hit), .o_wdt_enable(wdt));
  task check(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task cfg(input row_s r);
    @(negedge clk);
    {ae, de, re, sz, dr, c2} = r.f;
    ld = 1;
    @(negedge clk);
    ld = 0;
  endtask : cfg
  task acc(input row_s r);
    @(negedge clk);
    {a, d, w, go} = {r.a, r.d, r.w, 1'h1};
    @(negedge clk);
    go = 0;
    check(halt, r.ex != 2'h0);
    check(hit, r.ex);
    @(negedge clk);
    check(halt, 1'h0);
  endtask : acc
  task acc2(input row_s r);
    @(negedge clk);
    {a, d, w, go} = {r.a, r.d, r.w, 1'h1};
    @(negedge clk);
    check(halt, 1'h1);
    @(negedge clk);
    go = 0;
    check(halt, 1'h1);
    check(hit, r.ex);
    @(negedge clk);
    check(halt, 1'h0);
  endtask : acc2
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 0;
    check(wdt, 1'h1);
    act = 1;
    @(negedge clk);
    act = 0;
    @(negedge clk);
    check(wdt, 1'h0);
    // Channel two never set to coincide with channel one
    foreach (rows[i]) begin
      cfg(rows[i]);
      acc(rows[i]);
    end
    blk = rows[0];
    blk.ex = 2'h0;
    cfg(rows[0]);
    stp = 1;
    acc(blk);
    stp = 0;
    trp = 1;
    acc(blk);
    trp = 0;
    acc(rows[0]);
    acc2(rows[0]);
    rst = 1;
    @(negedge clk);
    rst = 0;
    check(wdt, 1'h1);
    cfg(blk);
    acc(blk);
    act = 1;
    @(negedge clk);
    act = 0;
    check(wdt, 1'h0);
    acc(blk);
    cfg(rows[0]);
    acc(rows[0]);
    finish_test();
  end
endmodule : tb
`default_nettype wire
